/* File: hw/ast_pkg.sv */
// package for the serial transceiver: offsets, field layouts, resets,
// bit timing and states.
// assumes a single system clock and a byte-wide register port.
package ast_pkg;

   // register offsets on the byte-wide register port
   localparam logic [2:0] AST_REG_DATA = 3'h0;     // write: holding, read: receive
   localparam logic [2:0] AST_REG_STATUS0 = 3'h1;  // line and error status
   localparam logic [2:0] AST_REG_CTRL0 = 3'h2;    // enables and character format
   localparam logic [2:0] AST_REG_CTRL1 = 3'h3;    // multidrop and interrupt choice
   localparam logic [2:0] AST_REG_DIV_HI = 3'h4;   // divider, upper byte
   localparam logic [2:0] AST_REG_DIV_LO = 3'h5;   // divider, lower byte
   localparam logic [2:0] AST_REG_ADDR_CMP = 3'h6; // own node address
   localparam logic [2:0] AST_REG_STATUS1 = 3'h7;  // multidrop receive status

   // control 0 layout, msb first
   typedef struct packed {
      logic tx_enable_ctl;     // transmitter on
      logic rx_enable_ctl;     // receiver on
      logic flow_gate_enable;  // clear-to-send gates new characters
      logic parity_enable_ctl; // ninth bit carries parity
      logic parity_odd;        // 1 odd, 0 even
      logic two_stop;          // 1 sends two stop bits
      logic [1:0] rsvd;        // read as zero
   } ast_ctrl0_t;

   // control 1 layout, msb first
   typedef struct packed {
      logic multidrop_enable;          // ninth bit carries address flag
      logic [1:0] match_scheme_select; // address matching scheme
      logic tx_address_flag;           // flag sent with the next byte written
      logic [2:0] rsvd;                // read as zero
      logic errors_only;               // receive interrupt on errors alone
   } ast_ctrl1_t;

   // status 0 layout, msb first
   typedef struct packed {
      logic rx_data_available; // receive register full
      logic parity_err;        // parity mismatch
      logic overrun_err;       // byte arrived while register full
      logic framing_err;       // first stop bit low
      logic break_seen;        // all-zero character with low stop
      logic tx_holding_empty;  // holding register can take a byte
      logic tx_idle;           // shifter idle, line high
      logic flow_clear;        // clear-to-send asserted
   } ast_status0_t;

   // reset values
   localparam logic [7:0] AST_CTRL0_RST = 8'h00;
   localparam logic [7:0] AST_CTRL1_RST = 8'h00;
   localparam logic [7:0] AST_ADDR_RST = 8'h00;

   // matching schemes
   localparam logic [1:0] AST_MATCH_ALL = 2'h0;     // every byte delivered
   localparam logic [1:0] AST_MATCH_ADDR = 2'h1;    // address bytes only
   localparam logic [1:0] AST_MATCH_HW = 2'h2;      // matched address and its data
   localparam logic [1:0] AST_MATCH_HW_DATA = 2'h3; // data of matched frames only

   // bit timing: sixteen divider ticks per bit, sample in the middle
   localparam logic [3:0] AST_TICK_LAST = 4'hF;
   localparam logic [3:0] AST_TICK_MID = 4'h7;
   localparam logic [2:0] AST_BIT_LAST = 3'h7;

   // character states, gray along start-data-ninth-stop
   typedef enum logic [2:0] {
      AST_IDLE = 3'b000,
      AST_START = 3'b001,
      AST_DATA = 3'b011,
      AST_NINTH = 3'b010,
      AST_STOP = 3'b110
   } ast_state_t;

endpackage

/* File: hw/ast_async_serial_transceiver.sv */
// serial transceiver: transmitter, receiver, shared 16-bit divider,
// byte-wide register port.
// assumes rxd and cts_n are already synchronous to mclk.
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// [R1] tx and rx independent, shared rate/format
// [R2] eight data bits, lsb first
// [R3] low start, one or two stop
// [R4] parity generated and checked, even/odd
// [R5] framing, parity, overrun, break flagged
// [R6] sixteen-bit divider from two byte registers
// [R7] separate transmit and receive enables
// [R8] holding empty reads 1 when free
// [R9] holding byte moves to shifter automatically
// [R10] tx interrupt while holding register empty
// [R11] data available reads 1 when full
// [R12] separate tx and rx interrupts, status cause
// [R13] rx interrupt on data+errors or errors
// [R14] address flag sent with each byte
// [R15] software keeps parity off in multidrop
// [R16] clear-to-send optionally gates transmit start
// [R17] multidrop enable, scheme field, compare address
// [R18] clear-to-send sampled one clock before start
// [R19] holding write clears holding empty flag
// [R20] address flag replaces parity bit position
// [R21] low first stop bit is framing error
module ast_async_serial_transceiver #(
   parameter logic [15:0] DIV_RESET = 16'h0001 // divider after reset
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rdata,
   // serial line
   output logic txd,
   input wire logic rxd,
   input wire logic cts_n,
   // interrupt requests
   output logic tx_irq,
   output logic rx_irq
);

   // software registers
   ast_pkg::ast_ctrl0_t ctrl0;   // enables and format
   ast_pkg::ast_ctrl1_t ctrl1;   // multidrop and interrupt choice
   logic [7:0] div_hi;           // divider upper byte
   logic [7:0] div_lo;           // divider lower byte
   logic [7:0] node_addr;        // own node address
   // divider
   logic [15:0] div_cnt;         // counts down to the next tick
   logic tick;                   // one-cycle sixteenth-of-bit pulse
   // transmitter
   ast_pkg::ast_state_t tx_state;
   logic [7:0] tx_hold;          // holding register
   logic tx_hold_flag;           // address flag captured with the byte
   logic tx_holding_empty;       // holding register free
   logic [7:0] tx_shift;         // outgoing shifter
   logic tx_ninth;               // parity or address flag
   logic tx_ninth_used;          // ninth bit present this character
   logic [3:0] tx_tick;          // ticks within a bit
   logic [2:0] tx_bit;           // data bit index
   logic tx_second_stop;         // in second stop bit
   logic cts_n_q;                // clear-to-send, one clock old
   logic tx_load;                // holding to shifter this cycle
   // receiver
   ast_pkg::ast_state_t rx_state;
   logic rx_in;                  // registered line sample
   logic [7:0] rx_shift;         // incoming shifter
   logic rx_ninth;               // received ninth bit
   logic [3:0] rx_tick;          // ticks within a bit
   logic [2:0] rx_bit;           // data bit index
   logic [7:0] rx_data;          // receive data register
   ast_pkg::ast_status0_t st;    // status flags (tx fields unused here)
   logic rx_addr_seen;           // last delivered byte was an address
   logic new_frame;              // first data byte after matched address
   logic frame_matched;          // current frame addressed to us
   logic pending_new;            // next data byte opens a frame
   logic rx_done;                // stop bit sampled this cycle
   logic rx_deliver;             // completed byte goes to the register
   logic rd_data;                // software reads the receive register
   logic wr_data;                // software writes the holding register
   logic rx_is_addr;             // completed byte carries address flag
   logic rx_match;               // completed address equals node address

   // register port decode
   assign rd_data = rd_strobe && (addr == ast_pkg::AST_REG_DATA);
   assign wr_data = wr_strobe && (addr == ast_pkg::AST_REG_DATA);

   // software writable registers
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl0 <= ast_pkg::ast_ctrl0_t'(ast_pkg::AST_CTRL0_RST);
         ctrl1 <= ast_pkg::ast_ctrl1_t'(ast_pkg::AST_CTRL1_RST);
         div_hi <= DIV_RESET[15:8];
         div_lo <= DIV_RESET[7:0];
         node_addr <= ast_pkg::AST_ADDR_RST;
      end else if (wr_strobe) begin
         unique case (addr)
            ast_pkg::AST_REG_CTRL0: begin
               ctrl0 <= ast_pkg::ast_ctrl0_t'({wdata[7:2], 2'h0}); // [R7]
            end
            ast_pkg::AST_REG_CTRL1: begin
               ctrl1 <= ast_pkg::ast_ctrl1_t'({wdata[7:4], 3'h0, wdata[0]}); // [R17] [R13]
            end
            ast_pkg::AST_REG_DIV_HI: begin
               div_hi <= wdata; // [R6]
            end
            ast_pkg::AST_REG_DIV_LO: begin
               div_lo <= wdata; // [R6]
            end
            ast_pkg::AST_REG_ADDR_CMP: begin
               node_addr <= wdata; // [R17]
            end
            default: begin
               // data and status offsets handled elsewhere
            end
         endcase
      end
   end

   // shared divider: one tick per sixteenth of a bit for both directions
   // a new divisor applies at the next reload: no half ticks
   always_ff @(posedge mclk) begin
      if (reset) begin
         div_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= (div_cnt == 16'h0000); // [R1]
         if (div_cnt == 16'h0000) begin
            div_cnt <= {div_hi, div_lo} - 16'h0001; // [R6]
         end else begin
            div_cnt <= div_cnt - 16'h0001;
         end
      end
   end

   // clear-to-send sampled one clock ahead of any start
   always_ff @(posedge mclk) begin
      if (reset) begin
         cts_n_q <= 1'b1;
      end else begin
         cts_n_q <= cts_n; // [R18]
      end
   end

   // start a character only from idle, enabled, and with the gate open
   assign tx_load = (tx_state == ast_pkg::AST_IDLE) && ctrl0.tx_enable_ctl && // [R7]
                    !tx_holding_empty && // [R9]
                    (!ctrl0.flow_gate_enable || !cts_n_q); // [R16] [R18]

   // holding register and its empty flag
   // a write in the load cycle keeps the new byte, so the write wins here
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_hold <= 8'h00;
         tx_hold_flag <= 1'b0;
         tx_holding_empty <= 1'b1;
      end else begin
         if (wr_data) begin
            tx_hold <= wdata;
            tx_hold_flag <= ctrl1.tx_address_flag; // [R14]
            tx_holding_empty <= 1'b0; // [R19] [R8]
         end else if (tx_load) begin
            tx_holding_empty <= 1'b1; // [R8]
         end
      end
   end

   // transmit sequencer; a clear-to-send drop mid-character is ignored
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_state <= ast_pkg::AST_IDLE;
         tx_shift <= 8'h00;
         tx_ninth <= 1'b0;
         tx_ninth_used <= 1'b0;
         tx_tick <= 4'h0;
         tx_bit <= 3'h0;
         tx_second_stop <= 1'b0;
         txd <= 1'b1;
      end else begin
         unique case (tx_state)
            ast_pkg::AST_IDLE: begin
               txd <= 1'b1;
               if (tx_load) begin
                  tx_state <= ast_pkg::AST_START;
                  tx_shift <= tx_hold;
                  tx_ninth_used <= ctrl1.multidrop_enable || ctrl0.parity_enable_ctl;
                  // address flag takes precedence over parity in multidrop
                  tx_ninth <= ctrl1.multidrop_enable ? tx_hold_flag : // [R14] [R20]
                              ((^tx_hold) ^ ctrl0.parity_odd); // [R4]
                  tx_tick <= 4'h0;
                  tx_bit <= 3'h0;
                  tx_second_stop <= 1'b0;
                  txd <= 1'b0; // [R3]
               end
            end
            ast_pkg::AST_START: begin
               if (tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == ast_pkg::AST_TICK_LAST) begin
                     tx_state <= ast_pkg::AST_DATA;
                     txd <= tx_shift[0]; // [R2]
                  end
               end
            end
            ast_pkg::AST_DATA: begin
               if (tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == ast_pkg::AST_TICK_LAST) begin
                     tx_shift <= {1'b0, tx_shift[7:1]}; // [R2]
                     tx_bit <= tx_bit + 3'h1;
                     if (tx_bit != ast_pkg::AST_BIT_LAST) begin
                        txd <= tx_shift[1];
                     end else if (tx_ninth_used) begin
                        tx_state <= ast_pkg::AST_NINTH;
                        txd <= tx_ninth; // [R20] [R4]
                     end else begin
                        tx_state <= ast_pkg::AST_STOP;
                        txd <= 1'b1; // [R3]
                     end
                  end
               end
            end
            ast_pkg::AST_NINTH: begin
               if (tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == ast_pkg::AST_TICK_LAST) begin
                     tx_state <= ast_pkg::AST_STOP;
                     txd <= 1'b1;
                  end
               end
            end
            ast_pkg::AST_STOP: begin
               if (tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == ast_pkg::AST_TICK_LAST) begin
                     if (ctrl0.two_stop && !tx_second_stop) begin
                        tx_second_stop <= 1'b1; // [R3]
                     end else begin
                        tx_state <= ast_pkg::AST_IDLE;
                     end
                  end
               end
            end
            default: begin
               tx_state <= ast_pkg::AST_IDLE;
            end
         endcase
      end
   end

   // receive sequencer: samples mid-bit, finishes at middle of first stop
   assign rx_done = (rx_state == ast_pkg::AST_STOP) && tick &&
                    (rx_tick == ast_pkg::AST_TICK_LAST);
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_state <= ast_pkg::AST_IDLE;
         rx_in <= 1'b1;
         rx_shift <= 8'h00;
         rx_ninth <= 1'b0;
         rx_tick <= 4'h0;
         rx_bit <= 3'h0;
      end else begin
         rx_in <= rxd;
         unique case (rx_state)
            ast_pkg::AST_IDLE: begin
               rx_tick <= 4'h0;
               rx_bit <= 3'h0;
               if (ctrl0.rx_enable_ctl && !rx_in) begin // [R7]
                  rx_state <= ast_pkg::AST_START;
               end
            end
            ast_pkg::AST_START: begin
               if (tick) begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == ast_pkg::AST_TICK_MID) begin
                     // a glitch shorter than half a bit is not a start
                     rx_state <= rx_in ? ast_pkg::AST_IDLE : ast_pkg::AST_DATA; // [R3]
                     rx_tick <= 4'h0;
                  end
               end
            end
            ast_pkg::AST_DATA: begin
               if (tick) begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == ast_pkg::AST_TICK_LAST) begin
                     rx_shift <= {rx_in, rx_shift[7:1]}; // [R2]
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == ast_pkg::AST_BIT_LAST) begin
                        rx_state <= (ctrl1.multidrop_enable || ctrl0.parity_enable_ctl) ?
                                    ast_pkg::AST_NINTH : ast_pkg::AST_STOP;
                     end
                  end
               end
            end
            ast_pkg::AST_NINTH: begin
               if (tick) begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == ast_pkg::AST_TICK_LAST) begin
                     rx_ninth <= rx_in;
                     rx_state <= ast_pkg::AST_STOP;
                  end
               end
            end
            ast_pkg::AST_STOP: begin
               if (tick) begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == ast_pkg::AST_TICK_LAST) begin
                     rx_state <= ast_pkg::AST_IDLE;
                  end
               end
            end
            default: begin
               rx_state <= ast_pkg::AST_IDLE;
            end
         endcase
      end
   end

   // multidrop filtering of completed bytes
   assign rx_is_addr = ctrl1.multidrop_enable && rx_ninth;
   assign rx_match = (rx_shift == node_addr);
   always_comb begin
      rx_deliver = 1'b1;
      if (ctrl1.multidrop_enable) begin
         unique case (ctrl1.match_scheme_select) // [R17]
            ast_pkg::AST_MATCH_ALL: rx_deliver = 1'b1;
            ast_pkg::AST_MATCH_ADDR: rx_deliver = rx_is_addr;
            ast_pkg::AST_MATCH_HW: rx_deliver = rx_is_addr ? rx_match : frame_matched;
            ast_pkg::AST_MATCH_HW_DATA: rx_deliver = !rx_is_addr && frame_matched;
         endcase
      end
   end

   // frame tracking for the automatic schemes
   always_ff @(posedge mclk) begin
      if (reset) begin
         frame_matched <= 1'b0;
         pending_new <= 1'b0;
      end else if (rx_done && rx_is_addr) begin
         frame_matched <= rx_match; // [R17]
         pending_new <= rx_match;
      end else if (rx_done && rx_deliver) begin
         pending_new <= 1'b0;
      end
   end

   // receive register and status; a new event beats a same-cycle clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_data <= 8'h00;
         st <= '0;
         rx_addr_seen <= 1'b0;
         new_frame <= 1'b0;
      end else begin
         if (rd_data) begin
            st.rx_data_available <= 1'b0;
            st.parity_err <= 1'b0;
            st.overrun_err <= 1'b0;
            st.framing_err <= 1'b0;
            st.break_seen <= 1'b0;
         end
         if (rx_done) begin
            st.framing_err <= !rx_in; // [R21] [R5]
            st.break_seen <= !rx_in && (rx_shift == 8'h00) && !rx_ninth; // [R5]
            st.parity_err <= ctrl0.parity_enable_ctl && !ctrl1.multidrop_enable && // [R4]
                             ((^rx_shift ^ rx_ninth) != ctrl0.parity_odd); // [R5]
            if (rx_deliver) begin
               rx_data <= rx_shift;
               st.rx_data_available <= 1'b1; // [R11]
               st.overrun_err <= st.rx_data_available && !rd_data; // [R5]
               rx_addr_seen <= rx_is_addr;
               new_frame <= !rx_is_addr && pending_new;
            end
         end
      end
   end

   // interrupt requests, registered straight to the pins
   always_ff @(posedge mclk) begin
      if (reset) begin
         tx_irq <= 1'b0;
         rx_irq <= 1'b0;
      end else begin
         tx_irq <= ctrl0.tx_enable_ctl && tx_holding_empty; // [R10] [R12]
         rx_irq <= ctrl0.rx_enable_ctl && // [R12]
                   ((st.rx_data_available && !ctrl1.errors_only) || // [R13]
                    st.parity_err || st.overrun_err || st.framing_err || st.break_seen);
      end
   end

   // read data stands for one cycle after the strobe, zero otherwise
   always_ff @(posedge mclk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (rd_strobe) begin
         unique case (addr)
            ast_pkg::AST_REG_DATA: rdata <= rx_data;
            ast_pkg::AST_REG_STATUS0: begin
               rdata <= {st.rx_data_available, st.parity_err, st.overrun_err, // [R11]
                         st.framing_err, st.break_seen, tx_holding_empty, // [R8] [R12]
                         (tx_state == ast_pkg::AST_IDLE), !cts_n_q};
            end
            ast_pkg::AST_REG_CTRL0: rdata <= ctrl0;
            ast_pkg::AST_REG_CTRL1: rdata <= ctrl1;
            ast_pkg::AST_REG_DIV_HI: rdata <= div_hi;
            ast_pkg::AST_REG_DIV_LO: rdata <= div_lo;
            ast_pkg::AST_REG_ADDR_CMP: rdata <= node_addr;
            ast_pkg::AST_REG_STATUS1: rdata <= {6'h00, rx_addr_seen, new_frame};
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule // ast_async_serial_transceiver

`default_nettype wire

/* File: sim/ast_monitor.sv */
// checker: port relations of the transceiver
// assumes it is bound to the transceiver top, one clock domain
`timescale 1ns/100ps
`default_nettype none
module ast_monitor #(
   parameter logic [15:0] DIV_RESET = 16'h0001 // divider after reset
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire logic [2:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   input wire logic [7:0] rdata,
   // line and requests
   input wire logic txd,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic tx_irq,
   input wire logic rx_irq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [7:0] ctrl0; // shadow of control 0
   logic [7:0] div_lo; // shadow of divider low byte
   logic [7:0] node; // shadow of node address
   // shadows follow writes so readback can be predicted without the body
   always_ff @(posedge mclk) begin
      if (reset) begin
         ctrl0 <= ast_pkg::AST_CTRL0_RST;
         div_lo <= DIV_RESET[7:0];
         node <= ast_pkg::AST_ADDR_RST;
      end else if (wr_strobe) begin
         case (addr)
            ast_pkg::AST_REG_CTRL0: ctrl0 <= wdata;
            ast_pkg::AST_REG_DIV_LO: div_lo <= wdata;
            ast_pkg::AST_REG_ADDR_CMP: node <= wdata;
            default: ;
         endcase
      end
   end
   a_reset_quiet: assert property ($fell(reset) |->
      txd && !tx_irq && !rx_irq && rdata == 8'h00) else $error("reset outputs");
   a_write_clears: assert property (wr_strobe && addr == ast_pkg::AST_REG_DATA |->
      ##2 !tx_irq) else $error("tx request kept");
   a_start_width: assert property ($fell(txd) |-> (!txd) [*8])
      else $error("start too short");
   a_tx_off_quiet: assert property ((!ctrl0[7]) [*2] |-> !tx_irq)
      else $error("tx request off");
   a_rx_off_quiet: assert property ((!ctrl0[6]) [*2] |-> !rx_irq)
      else $error("rx request off");
   a_div_read: assert property (rd_strobe && addr == ast_pkg::AST_REG_DIV_LO |=>
      rdata == div_lo) else $error("div readback");
   a_ctrl_read: assert property (rd_strobe && addr == ast_pkg::AST_REG_CTRL0 |=>
      rdata == {ctrl0[7:2], 2'b00}) else $error("ctrl readback");
   a_node_read: assert property (rd_strobe && addr == ast_pkg::AST_REG_ADDR_CMP |=>
      rdata == node) else $error("addr readback");
endmodule // ast_monitor
bind ast_async_serial_transceiver ast_monitor #(.DIV_RESET(DIV_RESET)) ast_monitor_inst (
   .mclk, .reset, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata, .txd, .rxd, .cts_n,
   .tx_irq, .rx_irq);
`default_nettype wire

/* File: sim/ast_remote_node.sv */
// remote serial node: sends characters on rxd, captures them from txd
// assumes sixteen clocks per bit, i.e. a divider of one
`timescale 1ns/100ps
`default_nettype none
module ast_remote_node (
   // clock
   input wire logic mclk,
   // serial line
   input wire logic txd,
   output logic rxd,
   output logic cts_n
);
   logic [9:0] got; // bit positions after the last start bit
   int frames = 0; // characters captured so far
   initial begin
      rxd = 1'b1;
      cts_n = 1'b0;
   end
   // start, data lsb first, optional ninth, stop; a low stop is cut short
   task automatic send(input logic [7:0] d, input logic nin_on, input logic nin,
      input logic stop);
      logic [10:0] f;
      int s;
      f = nin_on ? {stop, nin, d, 1'b0} : {1'b1, stop, d, 1'b0};
      s = nin_on ? 10 : 9;
      for (int i = 0; i < 11; i++) begin
         @(posedge mclk) rxd <= f[i];
         repeat ((i == s && !f[i]) ? 12 : 15) @(posedge mclk);
      end
      @(posedge mclk) rxd <= 1'b1;
   endtask
   // clear-to-send level
   task automatic hold_off(input logic v);
      @(posedge mclk) cts_n <= v;
   endtask
   // sample txd mid-bit after a start edge
   initial forever begin
      @(negedge txd);
      repeat (8) @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
         repeat (16) @(posedge mclk);
         got[i] = txd;
      end
      frames++;
   end
endmodule // ast_remote_node
`default_nettype wire

/* File: sim/tb_async_serial_transceiver.sv */
// bench: register and line tests for the transceiver
// assumes the remote node model and bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_async_serial_transceiver;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic [7:0] rdata, v;
   logic txd, rxd, cts_n, tx_irq, rx_irq;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int m;
   localparam logic [2:0] DAT = ast_pkg::AST_REG_DATA, ST0 = ast_pkg::AST_REG_STATUS0;
   localparam logic [2:0] CT0 = ast_pkg::AST_REG_CTRL0, CT1 = ast_pkg::AST_REG_CTRL1;
   initial forever #12.5 mclk = ~mclk;
   ast_async_serial_transceiver #(.DIV_RESET(16'h0001)) ast_async_serial_transceiver_inst (
      .mclk, .reset, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata, .txd, .rxd, .cts_n,
      .tx_irq, .rx_irq);
   ast_remote_node ast_remote_node_inst (.mclk, .txd, .rxd, .cts_n);
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr_strobe <= 1'b1;
      @(posedge mclk);
      wr_strobe <= 1'b0;
   endtask
   // read data stand one cycle after the strobe
   task automatic rd(input logic [2:0] a);
      @(posedge mclk);
      addr <= a;
      rd_strobe <= 1'b1;
      @(posedge mclk);
      rd_strobe <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] msk = 8'hFF);
      rd(a);
      chk(v & msk, exp);
   endtask
   // wait for one more captured character, a missing one is an error
   task automatic fin(input int n, input logic [9:0] exp);
      repeat (400) if (ast_remote_node_inst.frames == n) @(posedge mclk);
      if (ast_remote_node_inst.frames == n) n_errors++;
      chk(ast_remote_node_inst.got, exp);
   endtask
   task automatic tx(input logic [7:0] d, input logic [9:0] exp);
      m = ast_remote_node_inst.frames;
      wr(ast_pkg::AST_REG_DATA, d);
      fin(m, exp);
   endtask
   task automatic rx(input logic [7:0] d, input logic nin, input logic stp,
      input logic [7:0] exp, input logic [7:0] msk = 8'hFF);
      ast_remote_node_inst.send(d, 1'b1, nin, stp);
      repeat (4) @(posedge mclk);
      rc(ST0, exp, msk);
   endtask
   task automatic results();
      if (n_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard, far above the run length
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         results();
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      rc(ST0, 8'h07);
      rc(ast_pkg::AST_REG_DIV_LO, 8'h01);
      wr(ast_pkg::AST_REG_DIV_HI, 8'h00);
      wr(ast_pkg::AST_REG_ADDR_CMP, 8'h12);
      rc(ast_pkg::AST_REG_ADDR_CMP, 8'h12);
      wr(CT0, 8'hD3);
      repeat (3) @(posedge mclk);
      chk(tx_irq, 10'h001);
      tx(8'hA5, {1'b1, ^8'hA5, 8'hA5});
      wr(CT0, 8'hDB);
      rc(CT0, 8'hD8);
      tx(8'h5B, {1'b1, ~^8'h5B, 8'h5B});
      rx(8'h3C, 1'b1, 1'b1, 8'h87);
      chk(rx_irq, 10'h001);
      rc(DAT, 8'h3C);
      rc(ST0, 8'h07);
      wr(CT0, 8'hD0);
      rx(8'h3C, 1'b1, 1'b1, 8'hC7);
      rd(DAT);
      rx(8'h81, 1'b0, 1'b0, 8'h17, 8'h7F);
      rd(DAT);
      rx(8'h00, 1'b0, 1'b0, 8'h1F, 8'h7F);
      rd(DAT);
      rx(8'h3C, 1'b0, 1'b1, 8'h87);
      rx(8'h66, 1'b0, 1'b1, 8'hA7);
      rd(DAT);
      wr(CT1, 8'h01);
      rx(8'h66, 1'b0, 1'b1, 8'h87);
      chk(rx_irq, 10'h000);
      rd(DAT);
      wr(CT0, 8'hC0); // parity stays off in multidrop
      tx(8'h96, {2'b11, 8'h96});
      wr(CT1, 8'h90);
      tx(8'h55, {2'b11, 8'h55});
      wr(CT1, 8'hA0);
      tx(8'hAA, {2'b10, 8'hAA});
      rx(8'h34, 1'b0, 1'b1, 8'h07);
      rx(8'h12, 1'b1, 1'b1, 8'h87);
      rc(DAT, 8'h12);
      wr(CT1, 8'h00);
      wr(CT0, 8'hE0);
      ast_remote_node_inst.hold_off(1'b1);
      m = ast_remote_node_inst.frames;
      wr(DAT, 8'h3C);
      repeat (60) @(posedge mclk);
      chk(txd, 10'h001);
      ast_remote_node_inst.hold_off(1'b0);
      fin(m, {2'b11, 8'h3C});
      wr(CT0, 8'h40);
      m = ast_remote_node_inst.frames;
      wr(DAT, 8'h77);
      repeat (60) @(posedge mclk);
      chk({txd, tx_irq}, 10'h002);
      wr(CT0, 8'hC0);
      fin(m, {2'b11, 8'h77});
      results();
   end
endmodule // tb_async_serial_transceiver
`default_nettype wire
